/* afme_pkg.sv */
// afme_pkg: constants, field positions and carriers for the axis fault,
// enable and smoothing block.
// assumes one 100 MHz clock and a synchronous active-high reset.
package afme_pkg;

  localparam int NUM_AXES   = 4;
  localparam int NUM_MASKS  = 7;
  localparam int FAULT_W    = 20;
  localparam int RAW_W      = 15;
  localparam int ADC_CHANS  = 4;
  localparam int ADC_W      = 16;
  localparam int TRAJ_W     = 32;
  localparam int TC_W       = 16;

  // mask index
  localparam logic [2:0] MASK_GLOBAL  = 3'h0;
  localparam logic [2:0] MASK_DISABLE = 3'h1;
  localparam logic [2:0] MASK_INTR    = 3'h2;
  localparam logic [2:0] MASK_AUX     = 3'h3;
  localparam logic [2:0] MASK_HALT    = 3'h4;
  localparam logic [2:0] MASK_ABORT   = 3'h5;
  localparam logic [2:0] MASK_BRAKE   = 3'h6;

  // fault word bit positions
  localparam int FB_POS_ERR   = 0;
  localparam int FB_RMS_ERR   = 1;
  localparam int FB_INT_ERR   = 2;
  localparam int FB_HW_LIM_P  = 3;
  localparam int FB_HW_LIM_N  = 4;
  localparam int FB_SW_LIM_N  = 5;
  localparam int FB_AMP_FLT   = 7;
  localparam int FB_FBK_ERR   = 8;
  localparam int FB_VFBK_FLT  = 9;
  localparam int FB_HALL_FLT  = 10;
  localparam int FB_RSVD_A    = 11;
  localparam int FB_FEED_MAX  = 12;
  localparam int FB_VEL_ERR   = 13;
  localparam int FB_ESTOP     = 14;
  localparam int FB_RSVD_B    = 15;
  localparam int FB_ANY_AXIS0 = 16;

  // bits that may ever report a fault (11, 15 and the unlisted 6 stay 0)
  localparam logic [FAULT_W-1:0] FAULT_VALID = 20'hF_77BF;
  localparam logic [RAW_W-1:0]   RAW_VALID   = 15'h7_7BF;
  localparam logic [FAULT_W-1:0] MASK_RESET  = 20'hF_77BF;

  localparam logic [TRAJ_W-1:0] TRAJ_RESET = 32'h0000_0000;
  localparam logic [TC_W-1:0]   TC_RESET   = 16'h0000;
  localparam logic [TC_W-1:0]   TC_OFF     = 16'h0000;
  localparam logic [TC_W-1:0]   TC_FLUSH   = 16'h0001;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic                valid;
    logic [NUM_AXES-1:0] axes;
    logic                scan;
  } afme_en_req_s;

  typedef struct packed {
    logic               valid;
    logic [1:0]         axis;
    logic [2:0]         sel;
    logic [FAULT_W-1:0] value;
  } afme_mask_wr_s;

  typedef struct packed {
    logic            valid;
    logic [1:0]      axis;
    logic [TC_W-1:0] value;
  } afme_tc_wr_s;

endpackage

/* afme_smooth.sv */
// afme_smooth: one-axis exponential smoothing of a commanded trajectory.
// assumes msTick is a one-cycle pulse once per millisecond, same clock.
`timescale 1ns/1ps
`default_nettype none
module afme_smooth (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           msTick,
  input  wire logic [afme_pkg::TC_W-1:0]      timeConst,
  input  wire logic signed [afme_pkg::TRAJ_W-1:0] trajIn,
  output logic signed [afme_pkg::TRAJ_W-1:0]  trajOut
);
  import afme_pkg::*;

  logic signed [TRAJ_W-1:0] state_q;
  logic signed [TRAJ_W:0]   diff;
  logic signed [TRAJ_W:0]   step;
  logic signed [TRAJ_W:0]   tcSigned;
  logic                     isOff;
  logic                     isFlush;

  assign isOff    = (timeConst == TC_OFF);
  assign isFlush  = (timeConst == TC_FLUSH);
  assign diff     = {trajIn[TRAJ_W-1], trajIn} - {state_q[TRAJ_W-1], state_q};
  assign tcSigned = $signed({{(TRAJ_W+1-TC_W){1'b0}}, timeConst});
  // a divider keeps any time constant exact; costs area, not speed at 1 kHz
  assign step     = (isOff || isFlush) ? diff : diff / tcSigned;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= TRAJ_RESET;
      trajOut <= TRAJ_RESET;
    end else if (isOff) begin
      trajOut <= trajIn;
    end else if (isFlush) begin
      state_q <= trajIn;
      trajOut <= trajIn;
    end else begin
      if (msTick) begin
        state_q <= state_q + step[TRAJ_W-1:0];
      end
      trajOut <= state_q;
    end
  end

endmodule // afme_smooth
`default_nettype wire

/* afme_axis_ctrl.sv */
// afme_axis_ctrl: axis enable, analog scan, fault latching, seven fault
// masks per axis, fault acknowledge with limit back-out, and smoothing.
// assumes fault, limit, analog and key inputs come from pins (synchronised
// here); request structs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module afme_axis_ctrl #(
  parameter int MS_COUNT = afme_pkg::MS_CYCLES
) (
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  input  wire afme_pkg::afme_en_req_s                 enableReq,
  input  wire afme_pkg::afme_en_req_s                 disableReq,
  input  wire afme_pkg::afme_mask_wr_s                maskWr,
  input  wire logic                                   maskRestore,
  input  wire afme_pkg::afme_tc_wr_s                  tcWr,
  input  wire logic                                   faultClearRequest,
  input  wire logic                                   faultClearKey,
  input  wire logic [3:0][afme_pkg::RAW_W-1:0]        faultIn,
  input  wire logic [3:0][afme_pkg::ADC_W-1:0]        adcIn,
  input  wire logic [3:0][afme_pkg::TRAJ_W-1:0]       trajIn,
  output logic [3:0]                                  ampOn,
  output logic [3:0]                                  loopClosed,
  output logic                                        scanActive,
  output logic [3:0][afme_pkg::ADC_W-1:0]             adcValue,
  output logic [3:0][afme_pkg::FAULT_W-1:0]           faultWord,
  output logic [3:0][6:0]                             maskAction,
  output logic [3:0]                                  backoutPos,
  output logic [3:0]                                  backoutNeg,
  output logic [3:0][afme_pkg::TRAJ_W-1:0]            smoothTraj
);
  import afme_pkg::*;

  // millisecond tick
  localparam int MSC_W = $clog2(MS_COUNT + 1);
  localparam logic [MSC_W-1:0] MS_LAST = MSC_W'(MS_COUNT - 1);
  localparam logic [MSC_W-1:0] MS_ZERO = '0;

  logic [MSC_W-1:0] msCnt_q;
  logic             msTick_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      msCnt_q  <= MS_ZERO;
      msTick_q <= 1'b0;
    end else begin
      msTick_q <= (msCnt_q == MS_LAST);
      msCnt_q  <= (msCnt_q == MS_LAST) ? MS_ZERO : msCnt_q + MSC_W'(1);
    end
  end

  // pin synchronisers; stage one is read only by stage two
  logic [3:0][RAW_W-1:0] faultS1_q;
  logic [3:0][RAW_W-1:0] faultS2_q;
  logic [3:0][ADC_W-1:0] adcS1_q;
  logic [3:0][ADC_W-1:0] adcS2_q;
  logic                  keyS1_q;
  logic                  keyS2_q;
  logic                  keyS3_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      faultS1_q <= '0;
      faultS2_q <= '0;
      adcS1_q   <= '0;
      adcS2_q   <= '0;
      keyS1_q   <= 1'b0;
      keyS2_q   <= 1'b0;
      keyS3_q   <= 1'b0;
    end else begin
      faultS1_q <= faultIn;
      faultS2_q <= faultS1_q;
      adcS1_q   <= adcIn;
      adcS2_q   <= adcS1_q;
      keyS1_q   <= faultClearKey;
      keyS2_q   <= keyS1_q;
      keyS3_q   <= keyS2_q;
    end
  end

  // acknowledge from command or from the key's rising edge
  wire faultAck = faultClearRequest | (keyS2_q & ~keyS3_q);

  // analog scan; holding registers keep their last value once stopped
  logic       scan_q;
  logic [1:0] scanChan_q;
  logic [3:0][ADC_W-1:0] adcHold_q;

  wire scanOn  = enableReq.valid & enableReq.scan;
  wire scanOff = disableReq.valid & disableReq.scan;

  always_ff @(posedge clk) begin
    if (rst) begin
      scan_q     <= 1'b0;
      scanChan_q <= 2'h0;
      adcHold_q  <= '0;
    end else begin
      if (scanOff) begin
        scan_q <= 1'b0;
      end else if (scanOn) begin
        scan_q <= 1'b1;
      end
      if (scan_q) begin
        scanChan_q <= scanChan_q + 2'h1;
        adcHold_q[scanChan_q] <= adcS2_q[scanChan_q];
      end
    end
  end

  assign scanActive = scan_q;
  assign adcValue   = adcHold_q;

  // latched faults, active masks, enable state per axis
  logic [3:0][RAW_W-1:0]              latch_q;
  logic [3:0][NUM_MASKS-1:0][FAULT_W-1:0] mask_q;
  logic [3:0]                         en_q;
  logic [3:0]                         boPos_q;
  logic [3:0]                         boNeg_q;
  logic [3:0][FAULT_W-1:0]            word_q;
  logic [3:0][6:0]                    act_q;
  logic [3:0][TC_W-1:0]               tc_q;
  logic [3:0]                         anyFault;
  logic [3:0][FAULT_W-1:0]            wordD;
  logic [3:0][6:0]                    actD;

  genvar a;
  genvar m;
  generate
    for (a = 0; a < NUM_AXES; a++) begin : g_axis
      wire [RAW_W-1:0] live   = faultS2_q[a] & RAW_VALID;
      wire             selWr  = maskWr.valid &&
                                (maskWr.axis == 2'(a)) &&
                                (maskWr.sel < 3'(NUM_MASKS));
      wire             enHit  = enableReq.valid & enableReq.axes[a];
      wire             disHit = disableReq.valid & disableReq.axes[a];
      wire             tcHit  = tcWr.valid && (tcWr.axis == 2'(a));

      assign anyFault[a] = |latch_q[a];

      assign wordD[a] = {anyFault, 1'b0, latch_q[a]} & FAULT_VALID;

      // global mask gates every other action
      for (m = 0; m < NUM_MASKS; m++) begin : g_mask
        assign actD[a][m] = |(word_q[a] & mask_q[a][MASK_GLOBAL]
                              & mask_q[a][m]);
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          latch_q[a] <= '0;
        end else if (faultAck) begin
          latch_q[a] <= live; // new faults win over the clear
        end else begin
          latch_q[a] <= latch_q[a] | live;
        end
      end

      always_ff @(posedge clk) begin
        if (rst || maskRestore) begin
          mask_q[a] <= {NUM_MASKS{MASK_RESET}}; // default untouched
        end else if (selWr) begin
          mask_q[a][maskWr.sel] <= maskWr.value & FAULT_VALID;
        end
      end

      // a fault disable wins over an enable in the same cycle
      always_ff @(posedge clk) begin
        if (rst) begin
          en_q[a] <= 1'b0;
        end else if (disHit || act_q[a][MASK_DISABLE]) begin
          en_q[a] <= 1'b0;
        end else if (enHit) begin
          en_q[a] <= 1'b1;
        end
      end

      // back-out runs while the limit input stays asserted
      always_ff @(posedge clk) begin
        if (rst) begin
          boPos_q[a] <= 1'b0;
          boNeg_q[a] <= 1'b0;
        end else begin
          if (faultAck && live[FB_HW_LIM_N]) begin
            boPos_q[a] <= 1'b1;
          end else if (!live[FB_HW_LIM_N]) begin
            boPos_q[a] <= 1'b0;
          end
          if (faultAck && live[FB_HW_LIM_P]) begin
            boNeg_q[a] <= 1'b1;
          end else if (!live[FB_HW_LIM_P]) begin
            boNeg_q[a] <= 1'b0;
          end
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          tc_q[a] <= TC_RESET;
        end else if (tcHit) begin
          tc_q[a] <= tcWr.value; // about ten ms suits feedhold
        end
      end

      afme_smooth u_smooth (
        .clk       (clk),
        .rst       (rst),
        .msTick    (msTick_q),
        .timeConst (tc_q[a]),
        .trajIn    (trajIn[a]),
        .trajOut   (smoothTraj[a])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      word_q <= '0;
      act_q  <= '0;
    end else begin
      word_q <= wordD;
      act_q  <= actD;
    end
  end

  // amplifier and loop follow the enable flop together
  assign ampOn      = en_q;
  assign loopClosed = en_q;
  assign faultWord  = word_q;
  assign maskAction = act_q;
  assign backoutPos = boPos_q;
  assign backoutNeg = boNeg_q;

endmodule // afme_axis_ctrl
`default_nettype wire

/* afme_plant_model.sv */
// afme_plant_model: far-side pins, i.e. amplifiers, feedback, sensors.
// assumes the bench sets wanted levels; pins follow one clock later.
`timescale 1ns/1ps
`default_nettype none
module afme_plant_model (
  input  wire logic                             clk,
  input  wire logic [3:0][afme_pkg::RAW_W-1:0] faultSet,
  input  wire logic [3:0][afme_pkg::ADC_W-1:0] adcSet,
  output logic      [3:0][afme_pkg::RAW_W-1:0] faultIn,
  output logic      [3:0][afme_pkg::ADC_W-1:0] adcIn
);
  import afme_pkg::*;
  // a cycle of lag, so the pin synchronisers never see a same-edge change
  always_ff @(posedge clk) begin
    faultIn <= faultSet;
    adcIn   <= adcSet;
  end
endmodule // afme_plant_model
`default_nettype wire

/* afme_axis_ctrl_props.sv */
// afme_axis_ctrl_props: port checks for the axis fault block.
// assumes it is bound into every afme_axis_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module afme_axis_ctrl_props #(
  parameter int MS_COUNT = 10
) (
  input wire logic                                clk,
  input wire logic                                rst,
  input wire afme_pkg::afme_en_req_s              enableReq,
  input wire afme_pkg::afme_en_req_s              disableReq,
  input wire afme_pkg::afme_tc_wr_s               tcWr,
  input wire logic                                faultClearRequest,
  input wire logic [3:0][afme_pkg::RAW_W-1:0]    faultIn,
  input wire logic [3:0][afme_pkg::TRAJ_W-1:0]   trajIn,
  input wire logic [3:0]                          ampOn,
  input wire logic [3:0]                          loopClosed,
  input wire logic                                scanActive,
  input wire logic [3:0][afme_pkg::FAULT_W-1:0]  faultWord,
  input wire logic [3:0][6:0]                     maskAction,
  input wire logic [3:0]                          backoutPos,
  input wire logic [3:0][afme_pkg::TRAJ_W-1:0]   smoothTraj
);
  import afme_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic tcLow_q;
  // axis 0 only: time constants 0 and 1 both pass the input through
  always_ff @(posedge clk) begin
    if (rst) tcLow_q <= 1'b1;
    else if (tcWr.valid && tcWr.axis == 2'h0) tcLow_q <= tcWr.value <= TC_FLUSH;
  end
  a_amp_loop_tie: assert property (ampOn == loopClosed)
    else $error("amplifier and loop state differ");
  a_enable_answer: assert property (enableReq.valid && enableReq.axes[0]
    && !disableReq.valid && !maskAction[0][1] ##1 !maskAction[0][1]
    |-> ampOn[0]) else $error("axis 0 not enabled");
  a_scan_start: assert property (enableReq.valid && enableReq.scan
    && !(disableReq.valid && disableReq.scan) |=> scanActive)
    else $error("scan did not start");
  a_reserved_zero: assert property (((faultWord[0] | faultWord[1]
    | faultWord[2] | faultWord[3]) & 20'h0_8840) == 20'h0_0000)
    else $error("reserved fault bit set");
  a_summary_bits: assert property (faultWord[0][19:16] == {
    |faultWord[3][14:0], |faultWord[2][14:0], |faultWord[1][14:0],
    |faultWord[0][14:0]}) else $error("summary bits wrong");
  a_action_cause: assert property (maskAction[1] != 7'h00
    |-> $past(faultWord[1]) != 20'h0_0000)
    else $error("action without fault");
  a_ack_clears: assert property ((faultIn == '0)[*3] ##0 faultClearRequest
    |-> ##2 faultWord[1][14:0] == 15'h0000) else $error("ack left faults");
  a_backout_start: assert property (faultIn[2][4][*3] ##0
    faultClearRequest |=> backoutPos[2]) else $error("no back-out");
  a_filter_pass: assert property ($past(tcLow_q) && !$past(rst)
    |-> smoothTraj[0] == $past(trajIn[0])) else $error("filter not bypassed");
  c_all_actions: cover property (maskAction[1] == 7'h7F);
  c_backout: cover property (backoutPos[2]);
  c_scan_on: cover property (scanActive && ampOn[0]);
endmodule // afme_axis_ctrl_props
bind afme_axis_ctrl afme_axis_ctrl_props #(.MS_COUNT(MS_COUNT)) u_props (.*);
`default_nettype wire

/* afme_axis_ctrl_tb.sv */
// afme_axis_ctrl_tb: directed bench for the axis fault block.
// assumes a 100 MHz clock; a millisecond is shortened to 10 cycles.
`timescale 1ns/1ps
`default_nettype none
module afme_axis_ctrl_tb;
  import afme_pkg::*;
  logic clk = 1'b0, rst = 1'b1, restore = 1'b0, clrReq = 1'b0, clrKey = 1'b0;
  afme_en_req_s enReq = '0, disReq = '0;
  afme_mask_wr_s mWr = '0;
  afme_tc_wr_s tWr = '0;
  logic [3:0][RAW_W-1:0] fSet = '0, faultIn;
  logic [3:0][ADC_W-1:0] aSet = '0, adcIn, adcValue;
  logic [3:0][TRAJ_W-1:0] traj = '0, smoothTraj;
  logic [3:0] ampOn, loopClosed, bPos, bNeg;
  logic scanActive;
  logic [3:0][FAULT_W-1:0] faultWord;
  logic [3:0][6:0] maskAction;
  logic [6:0] expAct;
  logic [3:0][ADC_W-1:0] adcExp = {16'hA3A3, 16'h5C5C, 16'h0F0F, 16'hF0F0};
  int error_cnt = 0, tests_run = 0;
  always #5 clk = ~clk;
  afme_plant_model PLANT (.clk(clk), .faultSet(fSet), .adcSet(aSet),
    .faultIn(faultIn), .adcIn(adcIn));
  afme_axis_ctrl #(.MS_COUNT(10)) DUT (.clk(clk), .rst(rst),
    .enableReq(enReq), .disableReq(disReq), .maskWr(mWr),
    .maskRestore(restore), .tcWr(tWr), .faultClearRequest(clrReq),
    .faultClearKey(clrKey), .faultIn(faultIn), .adcIn(adcIn), .trajIn(traj),
    .ampOn(ampOn), .loopClosed(loopClosed), .scanActive(scanActive),
    .adcValue(adcValue), .faultWord(faultWord), .maskAction(maskAction),
    .backoutPos(bPos), .backoutNeg(bNeg), .smoothTraj(smoothTraj));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic endis(input logic [3:0] ax, input logic sc, input logic on);
    @(posedge clk);
    if (on) enReq <= '{1'b1, ax, sc};
    else disReq <= '{1'b1, ax, sc};
    @(posedge clk);
    enReq <= '0;
    disReq <= '0;
  endtask
  task automatic mask(input logic [2:0] sel, input logic [19:0] v);
    @(posedge clk) mWr <= '{1'b1, 2'd1, sel, v};
    @(posedge clk) mWr <= '0;
  endtask
  task automatic ack();
    @(posedge clk) clrReq <= 1'b1;
    @(posedge clk) clrReq <= 1'b0;
  endtask
  task automatic setTc(input logic [15:0] v);
    @(posedge clk) tWr <= '{1'b1, 2'd0, v};
    @(posedge clk) tWr <= '0;
  endtask
  // a slow or missing step ends the run instead of hanging it
  task automatic waitTraj(input logic [31:0] exp);
    logic [31:0] old;
    int n;
    old = smoothTraj[0];
    n = 0;
    while (smoothTraj[0] === old && n < 40) begin
      tick(1);
      n++;
    end
    if (n == 40) begin
      chk(32'h0, 32'h1);
      conclude();
    end else begin
      chk(smoothTraj[0], exp);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    endis(4'b0011, 1'b1, 1'b1);
    @(posedge clk) aSet <= adcExp;
    tick(1);
    chk(ampOn, 4'b0011);
    chk(loopClosed, 4'b0011);
    chk(scanActive, 1'b1);
    tick(12);
    for (int i = 0; i < 4; i++) chk(adcValue[i], adcExp[i]);
    endis(4'b0001, 1'b1, 1'b0);
    @(posedge clk) aSet <= ~adcExp;
    tick(12);
    chk(scanActive, 1'b0);
    chk(ampOn, 4'b0010);
    for (int i = 0; i < 4; i++) chk(adcValue[i], adcExp[i]);
    $display("test enable and scan done");
    @(posedge clk) fSet[1] <= 15'h7FFF;
    tick(8);
    chk(faultWord[1], 20'h2_77BF);
    chk(faultWord[0], 20'h2_0000);
    chk(maskAction[1], 7'h7F);
    chk(ampOn[1], 1'b0);
    expAct = 7'h7F;
    for (int m = 1; m < 7; m++) begin
      mask(3'(m), 20'h0_0000);
      tick(2);
      expAct[m] = 1'b0;
      chk(maskAction[1], expAct);
    end
    mask(3'h7, 20'h0_0000);
    tick(2);
    chk(maskAction[1], 7'h01);
    @(posedge clk) restore <= 1'b1;
    @(posedge clk) restore <= 1'b0;
    tick(3);
    chk(maskAction[1], 7'h7F);
    mask(MASK_GLOBAL, 20'h0_0000);
    tick(2);
    chk(maskAction[1], 7'h00);
    $display("test masks done");
    @(posedge clk) fSet[1] <= '0;
    tick(6);
    chk(faultWord[1], 20'h2_77BF);
    ack();
    tick(3);
    chk(faultWord[1], 20'h0_0000);
    chk(faultWord[0], 20'h0_0000);
    @(posedge clk) fSet[2][FB_HW_LIM_N] <= 1'b1;
    tick(6);
    ack();
    tick(2);
    chk({bPos[2], bNeg[2], faultWord[2][4]}, 3'b101);
    @(posedge clk) fSet[2] <= '0;
    tick(6);
    chk(bPos[2], 1'b0);
    @(posedge clk) fSet[3][FB_HW_LIM_P] <= 1'b1;
    tick(6);
    @(posedge clk) clrKey <= 1'b1;
    tick(6);
    chk({bNeg[3], bPos[3]}, 2'b10);
    $display("test acknowledge done");
    @(posedge clk) traj[0] <= 32'h1234_5678;
    tick(3);
    chk(smoothTraj[0], 32'h1234_5678);
    setTc(16'h0001);
    @(posedge clk) traj[0] <= 32'h0000_0000;
    tick(3);
    chk(smoothTraj[0], 32'h0000_0000);
    setTc(16'h000A);
    @(posedge clk) traj[0] <= 32'h0000_0064;
    tick(1);
    waitTraj(32'h0000_000A);
    waitTraj(32'h0000_0013);
    waitTraj(32'h0000_001B);
    $display("test smoothing done");
    conclude();
  end
endmodule // afme_axis_ctrl_tb
`default_nettype wire
